/* hdl/panel_pkg.sv */
// Constants and types shared by the front-panel status display controller.
// Assumes one 25 MHz clock, active-high keys, synchronous inputs.
package panel_pkg;
	// ==================================================
	// Timing
	localparam int CLK_HZ = 25_000_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;

	// ==================================================
	// Display and items
	localparam int DIGITS = 5;
	localparam int ITEM_COUNT = 16;
	localparam int MON_COUNT = 6;
	localparam int CONV_STEPS = 10;
	localparam logic [3:0] RESET_ITEM = 4'h0;
	localparam logic [3:0] ITEM_FB_HI_PRE = 4'h0;
	localparam logic [3:0] ITEM_FB_LO_PRE = 4'h1;
	localparam logic [3:0] ITEM_CMD_HI_PRE = 4'h2;
	localparam logic [3:0] ITEM_CMD_LO_PRE = 4'h3;
	localparam logic [3:0] ITEM_DEV_PRE = 4'h4;
	localparam logic [3:0] ITEM_FB_HI_POST = 4'h5;
	localparam logic [3:0] ITEM_FB_LO_POST = 4'h6;
	localparam logic [3:0] ITEM_CMD_HI_POST = 4'h7;
	localparam logic [3:0] ITEM_CMD_LO_POST = 4'h8;
	localparam logic [3:0] ITEM_DEV_POST = 4'h9;
	localparam logic [3:0] ITEM_MON_BASE = 4'hA;
	localparam logic [31:0] DEC_BASE = 32'h0000000A;
	localparam logic [7:0] SEG_BLANK = 8'h00;
	localparam logic [7:0] SEG_MINUS = 8'h40;
	localparam int DP_BIT = 7;

	// ==================================================
	// Types
	typedef enum logic [3:0] {
		MODE_STATUS,
		MODE_TUNING,
		MODE_ALARM,
		MODE_DIAG,
		MODE_BASIC,
		MODE_GAIN,
		MODE_EXT,
		MODE_IO,
		MODE_POS1,
		MODE_POS2
	} mode_type;

	typedef struct packed {
		logic mode;
		logic up;
		logic down;
		logic set;
	} keys_type;

	typedef struct packed {
		logic signed [31:0] fb_pre;
		logic signed [31:0] fb_post;
		logic signed [31:0] cmd_pre;
		logic signed [31:0] cmd_post;
	} counts_type;

	typedef struct packed {
		logic is_hex;
		logic [15:0] lo;
		logic [15:0] hi;
	} limits_type;

	typedef struct packed {
		logic done;
		logic fail;
		logic range;
	} write_result_type;

	typedef logic [MON_COUNT-1:0][31:0] monitor_type;
	typedef logic [DIGITS-1:0][7:0] display_type;

	// ==================================================
	// Helpers
	function automatic logic [7:0] seg_of(input logic [3:0] d);
		logic [7:0] s;
		case (d)
			4'h0: s = 8'h3F;
			4'h1: s = 8'h06;
			4'h2: s = 8'h5B;
			4'h3: s = 8'h4F;
			4'h4: s = 8'h66;
			4'h5: s = 8'h6D;
			4'h6: s = 8'h7D;
			4'h7: s = 8'h07;
			4'h8: s = 8'h7F;
			4'h9: s = 8'h6F;
			4'hA: s = 8'h77;
			4'hB: s = 8'h7C;
			4'hC: s = 8'h39;
			4'hD: s = 8'h5E;
			4'hE: s = 8'h79;
			default: s = 8'h71;
		endcase
		return s;
	endfunction

	// Decimal limits clamp the whole value, hex limits clamp each digit
	function automatic logic [15:0] edit_step(input logic [15:0] v, input limits_type l,
		input logic [1:0] p, input logic up);
		logic [15:0] r;
		logic [3:0] n;
		logic [3:0] lo;
		logic [3:0] hi;
		r = v;
		n = v[{p, 2'b00} +: 4];
		lo = l.lo[{p, 2'b00} +: 4];
		hi = l.hi[{p, 2'b00} +: 4];
		if (l.is_hex) begin
			if (up) begin
				n = (n >= hi) ? hi : ((n < lo) ? lo : n + 4'h1);
			end else begin
				n = (n <= lo) ? lo : ((n > hi) ? hi : n - 4'h1);
			end
			r[{p, 2'b00} +: 4] = n;
		end else if (up) begin
			r = (v >= l.hi) ? l.hi : ((v < l.lo) ? l.lo : v + 16'h0001);
		end else begin
			r = (v <= l.lo) ? l.lo : ((v > l.hi) ? l.hi : v - 16'h0001);
		end
		return r;
	endfunction

	function automatic logic in_range(input logic [15:0] v, input limits_type l);
		logic ok;
		ok = 1'b1;
		if (l.is_hex) begin
			for (int i = 0; i < 4; i++) begin
				if (v[i*4 +: 4] < l.lo[i*4 +: 4] || v[i*4 +: 4] > l.hi[i*4 +: 4]) begin
					ok = 1'b0;
				end
			end
		end else begin
			ok = (v >= l.lo) && (v <= l.hi);
		end
		return ok;
	endfunction
endpackage

/* hdl/key_filter.sv */
// Debounce filter for one key, giving one pulse per accepted press.
// Assumes the raw key level is synchronous to mclk_i.
`timescale 1ns/1ps
module key_filter #(
	parameter int STABLE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Key
	input wire logic raw_i,
	output logic press_o
);
	import panel_pkg::*;

	localparam int CW = $clog2(STABLE_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic level;
		logic press;
	} filt_type;

	filt_type st;
	filt_type nx;

	// ==================================================
	// Filter
	// A level must hold STABLE_CYCLES samples; bounce restarts the count
	always_comb begin
		nx = st;
		nx.press = 1'b0;
		if (raw_i == st.level) begin
			nx.cnt = '0;
		end else if (st.cnt == CW'(STABLE_CYCLES - 1)) begin
			nx.cnt = '0;
			nx.level = raw_i;
			nx.press = raw_i;
		end else begin
			nx.cnt = st.cnt + CW'(1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign press_o = st.press;
endmodule

/* hdl/panel_status_display_ctrl.sv */
// Front-panel controller: mode stepping, status items, number display,
// parameter edit and write outcome.
// Assumes raw keys, debounced here through key_filter, and counters owned elsewhere.
`timescale 1ns/1ps
module panel_status_display_ctrl #(
	parameter int DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Operator keys
	input wire panel_pkg::keys_type keys_i,
	// Configuration
	input wire logic extended_param_enable_i,
	input wire logic servo_on_input_i,
	// Counters and monitor values
	input wire panel_pkg::counts_type counts_i,
	input wire panel_pkg::monitor_type monitor_i,
	// Parameter under edit
	input wire logic [15:0] param_value_i,
	input wire panel_pkg::limits_type limits_i,
	// Display
	output panel_pkg::display_type seg_o,
	output panel_pkg::mode_type mode_o,
	output logic [3:0] item_o,
	output logic showing_data_o,
	output logic editing_o,
	// Actions and outcome
	output logic count_clear_o,
	output logic param_write_o,
	output logic [15:0] param_data_o,
	output panel_pkg::write_result_type result_o
);
	import panel_pkg::*;

	typedef struct packed {
		mode_type mode;
		logic [3:0] item;
		logic show_data;
		logic editing;
		logic [1:0] edit_pos;
		logic [15:0] edit_val;
		logic [3:0] conv_step;
		logic [31:0] conv_mag;
		logic conv_neg;
		logic conv_hi;
		logic [39:0] conv_bcd;
		logic [19:0] show_bcd;
		logic show_neg;
		display_type seg;
		logic count_clear;
		logic param_write;
		write_result_type result;
	} state_type;

	state_type st;
	state_type nx;

	// ==================================================
	// Key filters
	logic [3:0] key_raw;
	logic [3:0] key_press;
	keys_type press;

	assign key_raw = keys_i;
	assign press = key_press;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_key
			key_filter #(
				.STABLE_CYCLES(DEBOUNCE_CYCLES)
			) u_filter (
				.mclk_i(mclk_i),
				.rstn_i(rstn_i),
				.raw_i(key_raw[g]),
				.press_o(key_press[g])
			);
		end
	endgenerate

	// ==================================================
	// Helpers
	function automatic mode_type mode_after(input mode_type m, input logic ext_en);
		mode_type n;
		if (m == MODE_POS2) begin
			n = MODE_STATUS;
		end else begin
			n = mode_type'(m + 4'h1);
		end
		if (n == MODE_EXT && !ext_en) begin
			n = MODE_IO;
		end
		return n;
	endfunction

	// ==================================================
	// Next state
	logic signed [31:0] dev_pre;
	logic signed [31:0] dev_post;
	logic signed [31:0] src;
	logic src_hi;
	logic [19:0] part;
	logic param_mode;
	logic any_press;
	logic lead;
	logic [2:0] sig_cnt;
	logic [3:0] dig;
	display_type rend;

	assign dev_pre = counts_i.cmd_pre - counts_i.fb_pre;
	assign dev_post = counts_i.cmd_post - counts_i.fb_post;

	always_comb begin
		nx = st;
		src = '0;
		src_hi = 1'b0;
		part = '0;
		lead = 1'b1;
		sig_cnt = '0;
		dig = '0;
		rend = '0;
		param_mode = (st.mode >= MODE_BASIC) && (st.mode != MODE_EXT || extended_param_enable_i);
		any_press = |key_press;
		nx.count_clear = 1'b0;
		nx.param_write = 1'b0;
		// Outcome stays up until the operator touches a key
		if (any_press) begin
			nx.result = '0;
		end

		// Mode key is the digit shift while editing
		if (press.mode) begin
			if (st.editing) begin
				nx.edit_pos = st.edit_pos + 2'h1;
			end else begin
				nx.mode = mode_after(st.mode, extended_param_enable_i);
				nx.show_data = 1'b0;
			end
		end else if (st.mode == MODE_STATUS) begin
			if (press.up && !press.down) begin
				nx.item = (st.item == 4'(ITEM_COUNT - 1)) ? '0 : st.item + 4'h1;
			end else if (press.down && !press.up) begin
				nx.item = (st.item == '0) ? 4'(ITEM_COUNT - 1) : st.item - 4'h1;
			end
			if (press.set) begin
				if (st.show_data) begin
					nx.count_clear = 1'b1;
				end else begin
					nx.show_data = 1'b1;
				end
			end
		end else if (param_mode) begin
			if (!st.editing) begin
				if (press.set) begin
					nx.editing = 1'b1;
					nx.edit_val = param_value_i;
					nx.edit_pos = '0;
				end
			end else begin
				if (press.up && !press.down) begin
					nx.edit_val = edit_step(st.edit_val, limits_i, st.edit_pos, 1'b1);
				end else if (press.down && !press.up) begin
					nx.edit_val = edit_step(st.edit_val, limits_i, st.edit_pos, 1'b0);
				end
				if (press.set) begin
					if (servo_on_input_i) begin
						nx.result.fail = 1'b1;
					end else if (!in_range(st.edit_val, limits_i)) begin
						nx.result.range = 1'b1;
					end else begin
						nx.param_write = 1'b1;
						nx.result.done = 1'b1;
						nx.editing = 1'b0;
					end
				end
			end
		end else begin
			nx.editing = 1'b0;
		end

		// Item source; high parts keep digits above the low five
		case (st.item)
			ITEM_FB_HI_PRE: begin
				src = counts_i.fb_pre;
				src_hi = 1'b1;
			end
			ITEM_FB_LO_PRE: src = counts_i.fb_pre;
			ITEM_CMD_HI_PRE: begin
				src = counts_i.cmd_pre;
				src_hi = 1'b1;
			end
			ITEM_CMD_LO_PRE: src = counts_i.cmd_pre;
			ITEM_DEV_PRE: src = dev_pre;
			ITEM_FB_HI_POST: begin
				src = counts_i.fb_post;
				src_hi = 1'b1;
			end
			ITEM_FB_LO_POST: src = counts_i.fb_post;
			ITEM_CMD_HI_POST: begin
				src = counts_i.cmd_post;
				src_hi = 1'b1;
			end
			ITEM_CMD_LO_POST: src = counts_i.cmd_post;
			ITEM_DEV_POST: src = dev_post;
			default: src = monitor_i[3'(st.item - ITEM_MON_BASE)];
		endcase
		if (st.editing && !limits_i.is_hex) begin
			src = {16'h0000, st.edit_val};
			src_hi = 1'b0;
		end

		// Serial divide by ten; one digit a cycle saves a wide divider tree
		if (st.conv_step == '0) begin
			nx.conv_mag = src[31] ? (~src + 32'h00000001) : src;
			nx.conv_neg = src[31];
			nx.conv_hi = src_hi;
			nx.conv_step = 4'h1;
		end else begin
			nx.conv_bcd = {4'(st.conv_mag % DEC_BASE), st.conv_bcd[39:4]};
			nx.conv_mag = st.conv_mag / DEC_BASE;
			if (st.conv_step == 4'(CONV_STEPS)) begin
				part = st.conv_hi ? nx.conv_bcd[39:20] : nx.conv_bcd[19:0];
				nx.show_bcd = part;
				nx.show_neg = st.conv_neg && (|part);
				nx.conv_step = '0;
			end else begin
				nx.conv_step = st.conv_step + 4'h1;
			end
		end

		// Rendering onto the five digits
		if ((st.mode == MODE_STATUS && st.show_data) || (st.editing && !limits_i.is_hex)) begin
			for (int k = DIGITS - 1; k >= 0; k--) begin
				dig = st.show_bcd[k*4 +: 4];
				if (lead && dig == 4'h0 && k != 0) begin
					rend[k] = SEG_BLANK;
				end else begin
					lead = 1'b0;
					rend[k] = seg_of(dig);
					sig_cnt = sig_cnt + 3'h1;
				end
			end
			if (st.show_neg) begin
				if (sig_cnt == 3'(DIGITS)) begin
					for (int k = 0; k < DIGITS; k++) begin
						rend[k][DP_BIT] = 1'b1;
					end
				end else begin
					rend[DIGITS-1] = SEG_MINUS;
				end
			end
		end else if (st.editing) begin
			for (int k = 0; k < 4; k++) begin
				rend[k] = seg_of(st.edit_val[k*4 +: 4]);
			end
			rend[st.edit_pos][DP_BIT] = 1'b1;
		end else if (st.mode == MODE_STATUS) begin
			rend[DIGITS-1] = seg_of(4'h5);
			rend[0] = seg_of(st.item);
		end else begin
			rend[DIGITS-1][DP_BIT] = 1'b1;
			rend[0] = seg_of(4'(st.mode));
		end
		nx.seg = rend;
	end

	// ==================================================
	// State register
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			st <= '0;
			st.mode <= MODE_STATUS;
			st.item <= RESET_ITEM;
		end else begin
			st <= nx;
		end
	end

	assign seg_o = st.seg;
	assign mode_o = st.mode;
	assign item_o = st.item;
	assign showing_data_o = st.show_data;
	assign editing_o = st.editing;
	assign count_clear_o = st.count_clear;
	assign param_write_o = st.param_write;
	assign param_data_o = st.edit_val;
	assign result_o = st.result;

	// ==================================================
	// Checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	a_mode_advance: assert property (
		press.mode && !st.editing && st.mode == MODE_STATUS |=> st.mode == MODE_TUNING)
		else $error("mode key did not advance from status");
	a_ext_skip: assert property (
		press.mode && !st.editing && st.mode == MODE_GAIN && !extended_param_enable_i
		|=> st.mode == MODE_IO)
		else $error("extended group entered while disabled");
	a_mode_order: assert property (
		press.mode && !st.editing && st.mode == MODE_DIAG |=> st.mode == MODE_BASIC)
		else $error("mode order broken after diagnostics");
	a_power_on: assert property (
		$past(!rstn_i) |-> st.mode == MODE_STATUS && !st.show_data)
		else $error("panel not in status mode after reset");
	a_item_step: assert property (
		st.mode == MODE_STATUS && press.up && !press.down && !press.mode
		|=> st.item == $past(st.item) + 4'h1)
		else $error("up key did not step the item");
	a_set_shows: assert property (
		st.mode == MODE_STATUS && !st.show_data && press.set && !press.mode
		|=> st.show_data ##1 st.seg != '0)
		else $error("set on symbol did not show data");
	a_conv_period: assert property (
		st.conv_step == 4'h0 |-> ##10 st.conv_step == 4'hA ##1 st.conv_step == 4'h0)
		else $error("digit conversion period wrong");
	a_neg_points: assert property (
		st.mode == MODE_STATUS && st.show_data && st.show_neg && st.show_bcd[19:16] != 4'h0
		|=> st.seg[0][DP_BIT] && st.seg[4][DP_BIT])
		else $error("five digit negative without points");
	a_neg_minus: assert property (
		st.mode == MODE_STATUS && st.show_data && st.show_neg && st.show_bcd[19:16] == 4'h0
		|=> st.seg[4] == SEG_MINUS)
		else $error("short negative without minus");
	a_son_refuse: assert property (
		st.editing && press.set && !press.mode && servo_on_input_i
		|=> st.result.fail && !st.param_write ##1 !st.param_write)
		else $error("write not refused with servo on");
	a_range_keep: assert property (
		st.result.range |-> !st.param_write && st.editing)
		else $error("out of range write went through");
	a_dec_clamp: assert property (
		st.editing && !limits_i.is_hex && press.down && !press.up && !press.mode
		&& st.edit_val <= limits_i.lo |=> st.edit_val == $past(limits_i.lo))
		else $error("decimal edit went under the limit");
	a_clear_pulse: assert property (
		st.count_clear |-> $past(press.set && st.show_data) ##1 !st.count_clear)
		else $error("count clear without set on data");
	a_mode_wrap: assert property (
		press.mode && !st.editing && st.mode == MODE_POS2 |=> st.mode == MODE_STATUS)
		else $error("mode did not wrap to status");

	c_last_group: cover property (st.mode == MODE_POS2);
	c_count_clear: cover property (st.count_clear);
	c_write_done: cover property (st.param_write ##1 st.result.done);
	c_write_fail: cover property (st.result.fail);
endmodule

/* dv/panel_operator.sv */
// Operator model: presses one key pattern, holds it, then releases it.
// Assumes one request at a time, raised only while busy_o is low.
`timescale 1ns/1ps
module panel_operator (
	// Clock
	input wire logic mclk_i,
	// Request from the bench
	input wire logic req_i,
	input wire panel_pkg::keys_type key_sel_i,
	input wire logic [7:0] hold_i,
	// Key levels and status
	output panel_pkg::keys_type keys_o,
	output logic busy_o
);
	import panel_pkg::*;
	// ==================================================
	// Press and release sequencer
	logic [8:0] count;
	logic [7:0] hold;
	initial begin
		keys_o = '0;
		busy_o = 1'b0;
		count = '0;
		hold = '0;
	end
	always @(posedge mclk_i) begin
		if (req_i && !busy_o) begin
			keys_o <= key_sel_i;
			hold <= hold_i;
			count <= 9'h001;
			busy_o <= 1'b1;
		end else if (busy_o) begin
			count <= count + 9'h001;
			if (count == {1'b0, hold})
				keys_o <= '0;
			// Release kept long so the filter sees a clean release too
			if (count == {1'b0, hold} + 9'h00C)
				busy_o <= 1'b0;
		end
	end
endmodule

/* dv/panel_status_display_ctrl_test.sv */
// Testbench for the front-panel controller, driven through the operator model.
// Assumes a debounce count of 4 and standard gfedcba digit patterns.
`timescale 1ns/1ps
module panel_status_display_ctrl_test;
	import panel_pkg::*;
	// ==================================================
	// Signals
	localparam int DEB = 4;
	localparam keys_type K_MODE = 4'h8;
	localparam keys_type K_UP = 4'h4;
	localparam keys_type K_DOWN = 4'h2;
	localparam keys_type K_SET = 4'h1;
	logic [7:0] segs [0:9] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07, 8'h7F, 8'h6F};
	longint exp_item [0:6] = '{9, 87777, 9, 87654, -123, -12345, -67890};
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	keys_type keys;
	logic ext_en = 1'b1;
	logic servo_on = 1'b0;
	counts_type counts;
	monitor_type monitor = '0;
	logic [15:0] param_value = 16'h000B;
	limits_type limits = '{1'b0, 16'h000A, 16'h000C};
	display_type seg_o;
	mode_type mode_o;
	logic [3:0] item_o;
	logic showing_data_o, editing_o, count_clear_o, param_write_o;
	logic [15:0] param_data_o;
	write_result_type result_o;
	logic req = 1'b0;
	keys_type key_sel = '0;
	logic [7:0] hold_len = 8'h08;
	logic busy;
	int n_fail = 0;
	int samples_checked = 0;
	int n_clear = 0;
	int n_write = 0;

	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (count_clear_o === 1'b1)
			n_clear++;
		if (param_write_o === 1'b1)
			n_write++;
	end

	// ==================================================
	// Instances
	panel_operator i_operator (.mclk_i(mclk_i), .req_i(req), .key_sel_i(key_sel), .hold_i(hold_len),
		.keys_o(keys), .busy_o(busy));
	panel_status_display_ctrl #(.DEBOUNCE_CYCLES(DEB)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.keys_i(keys), .extended_param_enable_i(ext_en), .servo_on_input_i(servo_on),
		.counts_i(counts), .monitor_i(monitor), .param_value_i(param_value), .limits_i(limits),
		.seg_o(seg_o), .mode_o(mode_o), .item_o(item_o), .showing_data_o(showing_data_o),
		.editing_o(editing_o), .count_clear_o(count_clear_o), .param_write_o(param_write_o),
		.param_data_o(param_data_o), .result_o(result_o));

	// ==================================================
	// Tasks
	task automatic final_report();
		$display("Checks: %0d, mismatches: %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// One key action; a short hold makes a bounce
	task automatic press(input keys_type k, input logic [7:0] hold);
		int i;
		key_sel = k;
		hold_len = hold;
		req = 1'b1;
		cycles(1);
		req = 1'b0;
		for (i = 0; i < 200 && busy !== 1'b0; i++)
			cycles(1);
		if (busy !== 1'b0) begin
			n_fail++;
			final_report();
		end
		cycles(2);
	endtask

	// Expected digits: leading zeros blank, sign by dp or leftmost minus
	function automatic display_type exp_disp(input longint v);
		display_type d;
		longint t;
		int nd;
		t = (v < 0) ? -v : v;
		nd = 0;
		for (int i = 0; i < DIGITS; i++) begin
			if (i == 0 || t != 0) begin
				d[i] = segs[t % 10];
				nd++;
			end else begin
				d[i] = SEG_BLANK;
			end
			t = t / 10;
		end
		if (v < 0 && nd == DIGITS) begin
			for (int i = 0; i < DIGITS; i++)
				d[i][DP_BIT] = 1'b1;
		end else if (v < 0) begin
			d[DIGITS-1] = SEG_MINUS;
		end
		return d;
	endfunction

	// ==================================================
	// Main sequence
	initial begin
		counts = '{32'sd987777, -32'sd1234567890, 32'sd987654, 32'sd0};
		cycles(4);
		rstn_i = 1'b1;
		cycles(2);
		chk(64'(mode_o), 64'(MODE_STATUS));
		chk(64'(item_o), 64'h0);
		chk(64'(seg_o[4]), 64'h6D);
		press(K_MODE, 8'h02);
		chk(64'(mode_o), 64'(MODE_STATUS));
		press(K_DOWN, 8'h08);
		chk(64'(item_o), 64'hF);
		press(K_UP, 8'h08);
		chk(64'(item_o), 64'h0);
		press(K_SET, 8'h08);
		chk(64'(showing_data_o), 64'h1);
		for (int i = 0; i < 7; i++) begin
			if (showing_data_o !== 1'b1)
				press(K_SET, 8'h08);
			cycles(30);
			chk(64'(item_o), 64'(i));
			chk(64'(seg_o), 64'(exp_disp(exp_item[i])));
			if (i < 6)
				press(K_UP, 8'h08);
		end
		chk(64'(n_clear), 64'h0);
		press(K_SET, 8'h08);
		chk(64'(n_clear), 64'h1);
		for (int i = 1; i <= 10; i++) begin
			press(K_MODE, 8'h08);
			chk(64'(mode_o), 64'(i % 10));
		end
		ext_en = 1'b0;
		for (int i = 0; i < 6; i++)
			press(K_MODE, 8'h08);
		chk(64'(mode_o), 64'(MODE_IO));
		// Decimal edit with clamp, refusal while servo on, then a good write
		press(K_SET, 8'h08);
		chk(64'(editing_o), 64'h1);
		repeat (3) press(K_UP, 8'h08);
		servo_on = 1'b1;
		press(K_SET, 8'h08);
		chk(64'(result_o), 64'h2);
		chk(64'(editing_o), 64'h1);
		chk(64'(n_write), 64'h0);
		servo_on = 1'b0;
		press(K_SET, 8'h08);
		chk(64'(result_o), 64'h4);
		chk(64'(n_write), 64'h1);
		chk(64'(param_data_o), 64'hC);
		chk(64'(editing_o), 64'h0);
		// Out-of-range loaded value refused, then written after the upper limit is raised and a down step
		param_value = 16'h0014;
		press(K_SET, 8'h08);
		press(K_SET, 8'h08);
		chk(64'(result_o), 64'h1);
		chk(64'(n_write), 64'h1);
		chk(64'(editing_o), 64'h1);
		limits = '{1'b0, 16'h000A, 16'h001E};
		press(K_DOWN, 8'h08);
		press(K_SET, 8'h08);
		chk(64'(param_data_o), 64'h13);
		chk(64'(n_write), 64'h2);
		// Hex edit: low nibble stops at its own upper limit
		limits = '{1'b1, 16'h0000, 16'h4444};
		param_value = 16'h3333;
		press(K_SET, 8'h08);
		repeat (3) press(K_UP, 8'h08);
		press(K_SET, 8'h08);
		chk(64'(param_data_o), 64'h3334);
		chk(64'(n_write), 64'h3);
		final_report();
	end
endmodule
